// [src/clock_select_pkg.sv]
// Constants and types shared by the system clock selection block
// Function
// - Strap low: no loop, input passed undivided.
// - Otherwise default bypass: input divided by two.
// - Nonzero multiplier: input times n, halved.
// - Reset defaults: high speed /2, low /4.
// - No valid input, strap high: fallback clock near 2 MHz.
// - All outputs launched from one clock.
package clock_select_pkg;
   // ----------------------------------------------------------------------
   // Configuration modes
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      mode_disabled = 2'b00,
      mode_bypassed = 2'b01,
      mode_enabled = 2'b10,
      mode_limp = 2'b11
   } clock_mode_t;

   // ----------------------------------------------------------------------
   // Widths and timing
   // ----------------------------------------------------------------------
   localparam int unsigned mult_width = 4;
   localparam int unsigned div_width = 8;
   localparam logic [3:0] mult_reset = 4'h0;
   localparam logic [7:0] hs_div_reset = 8'h02;
   localparam logic [7:0] ls_div_reset = 8'h04;
   localparam logic [7:0] conv_div_min = 8'h02;
   localparam int unsigned clock_mhz = 250;
   localparam int unsigned limp_khz = 2000;
   localparam int unsigned limp_half_cycles = (clock_mhz * 1000) / (2 * limp_khz);
   localparam logic [7:0] limp_half_count = 8'(limp_half_cycles);
   localparam logic [7:0] loss_timeout = 8'h40;
   localparam int unsigned div_stages = 4;
endpackage : clock_select_pkg

// [src/clock_divider_if.sv]
// Interface carrying one divider's setting and tick
`timescale 1ns/100ps
interface clock_divider_if;
   logic [7:0] divisor;
   logic tick;
   modport ctrl (output divisor, input tick);
   modport div (input divisor, output tick);
endinterface : clock_divider_if

// [src/clock_divider.sv]
// Programmable divider producing a one-cycle enable pulse
`timescale 1ns/100ps
module clock_divider (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic run,
   clock_divider_if.div port_d
);
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic tick_q;
   logic tick_d;

   always_comb begin
      count_d = count_q;
      tick_d = 1'b0;
      if (run) begin
         // Divisor 0 or 1 both mean every cycle
         if (count_q + 8'h01 >= port_d.divisor) begin
            count_d = 8'h00;
            tick_d = 1'b1;
         end else begin
            count_d = count_q + 8'h01;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= 8'h00;
         tick_q <= 1'b0;
      end else begin
         count_q <= count_d;
         tick_q <= tick_d;
      end
   end

   assign port_d.tick = tick_q;
endmodule : clock_divider

// [src/pll_system_clock_select.sv]
// System clock selection: strap latch, mode choice and derived clock enables
`timescale 1ns/100ps
module pll_system_clock_select (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic external_clock_input,
   input wire logic loop_disable_strap,
   input wire logic multiplier_write,
   input wire logic [3:0] multiplier_value,
   input wire logic loop_clock_tick,
   input wire logic [7:0] hs_divisor,
   input wire logic hs_divisor_write,
   input wire logic [7:0] ls_divisor,
   input wire logic ls_divisor_write,
   input wire logic [7:0] conv_divisor,
   input wire logic conv_divisor_write,
   output logic system_clock_out,
   output logic external_clock_output,
   output logic high_speed_peripheral_clock,
   output logic low_speed_peripheral_clock,
   output logic converter_clock,
   output logic [1:0] clock_mode,
   output logic [3:0] multiplier_control_register
);
   // ----------------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------------
   logic [1:0] ext_sync_q;
   logic [1:0] strap_sync_q;
   logic ext_last_q;

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         ext_sync_q <= 2'b00;
         ext_last_q <= 1'b0;
      end else begin
         ext_sync_q <= {ext_sync_q[0], external_clock_input};
         ext_last_q <= ext_sync_q[1];
      end
   end

   // Strap must be seen while reset is held, so it is not reset itself
   always_ff @(posedge clock) begin
      strap_sync_q <= {strap_sync_q[0], loop_disable_strap};
   end

   logic ext_rise;
   assign ext_rise = ext_sync_q[1] & ~ext_last_q;

   // ----------------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------------
   // Reset releases a one-cycle window in which the strap is captured
   logic in_reset_q;
   logic strap_low_q;
   logic strap_low_d;

   always_comb begin
      strap_low_d = strap_low_q;
      if (in_reset_q) begin
         strap_low_d = ~strap_sync_q[1];
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         in_reset_q <= 1'b1;
         strap_low_q <= 1'b0;
      end else begin
         in_reset_q <= 1'b0;
         strap_low_q <= strap_low_d;
      end
   end

   // ----------------------------------------------------------------------
   // Mode and multiplier
   // ----------------------------------------------------------------------
   logic [3:0] mult_q;
   logic [3:0] mult_d;
   logic [7:0] loss_q;
   logic [7:0] loss_d;
   clock_select_pkg::clock_mode_t mode_q;
   clock_select_pkg::clock_mode_t mode_d;

   always_comb begin
      mult_d = mult_q;
      if (multiplier_write && !in_reset_q && !strap_low_q) begin
         mult_d = multiplier_value;
      end
      // Input loss detector drives the fallback mode
      loss_d = loss_q;
      if (ext_rise) begin
         loss_d = 8'h00;
      end else if (loss_q != clock_select_pkg::loss_timeout) begin
         loss_d = loss_q + 8'h01;
      end
      if (in_reset_q) begin
         mode_d = clock_select_pkg::mode_bypassed;
      end else if (strap_low_q) begin
         mode_d = clock_select_pkg::mode_disabled;
      end else if (loss_q == clock_select_pkg::loss_timeout) begin
         mode_d = clock_select_pkg::mode_limp;
      end else if (mult_q != 4'h0) begin
         mode_d = clock_select_pkg::mode_enabled;
      end else begin
         mode_d = clock_select_pkg::mode_bypassed;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         mult_q <= clock_select_pkg::mult_reset;
         loss_q <= 8'h00;
         mode_q <= clock_select_pkg::mode_bypassed;
      end else begin
         mult_q <= mult_d;
         loss_q <= loss_d;
         mode_q <= mode_d;
      end
   end

   // ----------------------------------------------------------------------
   // System clock generation
   // ----------------------------------------------------------------------
   // Loop output is modelled as one tick per loop period, so n per input period
   logic sys_q;
   logic sys_d;
   logic half_q;
   logic half_d;
   logic [7:0] limp_q;
   logic [7:0] limp_d;

   always_comb begin
      sys_d = sys_q;
      half_d = half_q;
      limp_d = limp_q;
      unique case (mode_q)
         clock_select_pkg::mode_disabled: begin
            sys_d = ext_sync_q[1];
         end
         clock_select_pkg::mode_bypassed: begin
            if (ext_rise) begin
               sys_d = ~sys_q;
            end
         end
         clock_select_pkg::mode_enabled: begin
            if (loop_clock_tick) begin
               sys_d = ~sys_q;
            end
         end
         clock_select_pkg::mode_limp: begin
            if (limp_q + 8'h01 >= clock_select_pkg::limp_half_count) begin
               limp_d = 8'h00;
               sys_d = ~sys_q;
            end else begin
               limp_d = limp_q + 8'h01;
            end
         end
      endcase
      half_d = sys_d & ~sys_q;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         sys_q <= 1'b0;
         half_q <= 1'b0;
         limp_q <= 8'h00;
      end else begin
         sys_q <= sys_d;
         half_q <= half_d;
         limp_q <= limp_d;
      end
   end

   // ----------------------------------------------------------------------
   // Peripheral dividers
   // ----------------------------------------------------------------------
   clock_divider_if div_bus[3] ();
   logic [7:0] hs_q;
   logic [7:0] ls_q;
   logic [7:0] cv_q;
   logic [7:0] hs_d;
   logic [7:0] ls_d;
   logic [7:0] cv_d;

   always_comb begin
      hs_d = hs_divisor_write ? hs_divisor : hs_q;
      ls_d = ls_divisor_write ? ls_divisor : ls_q;
      cv_d = cv_q;
      if (conv_divisor_write) begin
         // Below two would equal the system clock rate
         cv_d = (conv_divisor < clock_select_pkg::conv_div_min) ?
                clock_select_pkg::conv_div_min : conv_divisor;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         hs_q <= clock_select_pkg::hs_div_reset;
         ls_q <= clock_select_pkg::ls_div_reset;
         cv_q <= clock_select_pkg::conv_div_min;
      end else begin
         hs_q <= hs_d;
         ls_q <= ls_d;
         cv_q <= cv_d;
      end
   end

   assign div_bus[0].divisor = hs_q;
   assign div_bus[1].divisor = ls_q;
   assign div_bus[2].divisor = cv_q;

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_div
         clock_divider u_div (
            .clock(clock),
            .rst_b(rst_b),
            .run(half_q),
            .port_d(div_bus[g])
         );
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Output registers, all on the one clock
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         system_clock_out <= 1'b0;
         external_clock_output <= 1'b0;
         high_speed_peripheral_clock <= 1'b0;
         low_speed_peripheral_clock <= 1'b0;
         converter_clock <= 1'b0;
         clock_mode <= 2'b01;
         multiplier_control_register <= 4'h0;
      end else begin
         system_clock_out <= sys_q;
         external_clock_output <= sys_q;
         // Ticks trail the system edge by a cycle; gating with it would hide them
         high_speed_peripheral_clock <= div_bus[0].tick;
         low_speed_peripheral_clock <= div_bus[1].tick;
         converter_clock <= div_bus[2].tick;
         clock_mode <= mode_q;
         multiplier_control_register <= mult_q;
      end
   end
endmodule : pll_system_clock_select

// [test/clock_select_monitor.sv]
// Checker on the ports of the system clock selection block
`timescale 1ns/100ps
module clock_select_monitor (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic multiplier_write,
   input wire logic [3:0] multiplier_value,
   input wire logic system_clock_out,
   input wire logic external_clock_output,
   input wire logic low_speed_peripheral_clock,
   input wire logic converter_clock,
   input wire logic [1:0] clock_mode,
   input wire logic [3:0] multiplier_control_register
);
   // ----------------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   property p_same; system_clock_out == external_clock_output; endproperty
   a_same: assert property (p_same)
      else $error("clock output differs from system clock");
   property p_conv_gap; converter_clock |=> !converter_clock; endproperty
   a_conv_gap: assert property (p_conv_gap)
      else $error("converter clock at system rate");
   property p_ls_gap; low_speed_peripheral_clock |=> !low_speed_peripheral_clock; endproperty
   a_ls_gap: assert property (p_ls_gap)
      else $error("low speed clock not divided");
   property p_mcr_hold;
      !$past(multiplier_write, 2) |-> $stable(multiplier_control_register);
   endproperty
   a_mcr_hold: assert property (p_mcr_hold)
      else $error("multiplier changed without a write");
   property p_mcr_load;
      multiplier_write && clock_mode != clock_select_pkg::mode_disabled
         |-> ##2 multiplier_control_register == $past(multiplier_value, 2);
   endproperty
   a_mcr_load: assert property (p_mcr_load)
      else $error("multiplier not loaded");
   property p_enable;
      clock_mode == clock_select_pkg::mode_bypassed && multiplier_write
         && multiplier_value != 4'h0 |-> ##3 clock_mode == clock_select_pkg::mode_enabled;
   endproperty
   a_enable: assert property (p_enable)
      else $error("loop not enabled by a nonzero multiplier");
   property p_dis_hold;
      clock_mode == clock_select_pkg::mode_disabled
         |=> clock_mode == clock_select_pkg::mode_disabled;
   endproperty
   a_dis_hold: assert property (p_dis_hold)
      else $error("disabled mode left after reset");
   property p_rst_mode; $rose(rst_b) |-> clock_mode == clock_select_pkg::mode_bypassed; endproperty
   a_rst_mode: assert property (p_rst_mode)
      else $error("mode after reset not bypass");
   property p_limp;
      clock_mode == clock_select_pkg::mode_limp && $changed(system_clock_out)
         |=> $stable(system_clock_out) [*8];
   endproperty
   a_limp: assert property (p_limp)
      else $error("fallback clock too fast");
   c_en: cover property (clock_mode == clock_select_pkg::mode_enabled);
   c_dis: cover property (clock_mode == clock_select_pkg::mode_disabled);
   c_limp: cover property (clock_mode == clock_select_pkg::mode_limp);
endmodule : clock_select_monitor

bind pll_system_clock_select clock_select_monitor u_mon (.clock(clock), .rst_b(rst_b),
   .multiplier_write(multiplier_write), .multiplier_value(multiplier_value),
   .system_clock_out(system_clock_out), .external_clock_output(external_clock_output),
   .low_speed_peripheral_clock(low_speed_peripheral_clock),
   .converter_clock(converter_clock), .clock_mode(clock_mode),
   .multiplier_control_register(multiplier_control_register));

// [test/clock_source_model.sv]
// Model of the external clock source, the loop output and the strap pin
`timescale 1ns/100ps
module clock_source_model (
   input wire logic clock,
   input wire logic run,
   input wire logic tick_run,
   input wire logic strap_level,
   input wire logic [3:0] mult,
   output logic external_clock_input,
   output logic loop_clock_tick,
   output logic loop_disable_strap
);
   // Input period in bench cycles: the source toggles every eighth cycle
   localparam int in_period = 16;
   int ph = 0;
   int acc = 0;
   initial begin
      external_clock_input = 1'b0;
      loop_clock_tick = 1'b0;
   end
   // Strap held steady by the bench across the whole reset
   assign loop_disable_strap = strap_level;
   // A stopped source stands still, so loss detection sees a dead input
   always @(negedge clock) begin
      if (run) begin
         ph <= (ph == 7) ? 0 : ph + 1;
         if (ph == 7) begin
            external_clock_input <= ~external_clock_input;
         end
      end
      // The loop gives n output periods per input period, one tick each
      if (run && tick_run && acc + int'(mult) >= in_period) begin
         acc <= acc + int'(mult) - in_period;
         loop_clock_tick <= 1'b1;
      end else begin
         acc <= (run && tick_run) ? acc + int'(mult) : acc;
         loop_clock_tick <= 1'b0;
      end
   end
endmodule : clock_source_model

// [test/tb_top.sv]
// Self-checking bench of the system clock selection block
`timescale 1ns/100ps
`define chk(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb_top;
   logic clock, rst_b, run, tick_run, strap_level, mw, cw;
   logic [3:0] mv, mcr;
   logic [7:0] cv;
   logic ext, tick, strap, sys, xo, hs, ls, conv;
   logic [1:0] mode;
   int error_cnt = 0, tests_run = 0;
   int n_sys, n_ext, n_tick, n_hs, n_ls, n_cv, n_diff;
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   clock_source_model src (.clock(clock), .run(run), .tick_run(tick_run),
      .strap_level(strap_level), .mult(mcr), .external_clock_input(ext), .loop_clock_tick(tick),
      .loop_disable_strap(strap));
   pll_system_clock_select uut (.clock(clock), .rst_b(rst_b), .external_clock_input(ext),
      .loop_disable_strap(strap), .multiplier_write(mw), .multiplier_value(mv),
      .loop_clock_tick(tick), .hs_divisor(8'h02), .hs_divisor_write(1'b0),
      .ls_divisor(8'h04), .ls_divisor_write(1'b0), .conv_divisor(cv),
      .conv_divisor_write(cw), .system_clock_out(sys), .external_clock_output(xo),
      .high_speed_peripheral_clock(hs), .low_speed_peripheral_clock(ls),
      .converter_clock(conv), .clock_mode(mode), .multiplier_control_register(mcr));
   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic count_edges(input int cycles);
      logic ps, pe;
      n_sys = 0;
      n_ext = 0;
      n_tick = 0;
      n_hs = 0;
      n_ls = 0;
      n_cv = 0;
      n_diff = 0;
      ps = sys;
      pe = ext;
      repeat (cycles) begin
         @(posedge clock);
         #1;
         n_sys += int'(sys !== ps);
         n_ext += int'(ext !== pe);
         n_tick += int'(tick === 1'b1);
         n_hs += int'(hs === 1'b1);
         n_ls += int'(ls === 1'b1);
         n_cv += int'(conv === 1'b1);
         n_diff += int'(xo !== sys);
         ps = sys;
         pe = ext;
      end
   endtask : count_edges
   task automatic do_reset(input logic s);
      @(negedge clock);
      strap_level = s;
      rst_b = 1'b0;
      repeat (6) @(negedge clock);
      rst_b = 1'b1;
      repeat (6) @(negedge clock);
   endtask : do_reset
   task automatic write_mult(input logic [3:0] v);
      @(negedge clock);
      mw = 1'b1;
      mv = v;
      @(negedge clock);
      mw = 1'b0;
   endtask : write_mult
   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic t_bypass;
      do_reset(1'b1);
      `chk("mode", clock_select_pkg::mode_bypassed, mode)
      `chk("mult", 4'h0, mcr)
      count_edges(640);
      `chk("half rate", 1'b1, n_sys * 2 >= n_ext - 2 && n_sys * 2 <= n_ext + 2)
      `chk("hs to ls", 1'b1, n_ls > 0 && n_hs >= 2 * n_ls - 1 && n_hs <= 2 * n_ls + 1)
      `chk("same edges", 0, n_diff)
   endtask : t_bypass
   task automatic t_enable;
      tick_run = 1'b1;
      write_mult(4'h3);
      repeat (4) @(negedge clock);
      `chk("mode", clock_select_pkg::mode_enabled, mode)
      `chk("mult", 4'h3, mcr)
      count_edges(400);
      `chk("loop rate", 1'b1, n_sys >= n_tick - 1 && n_sys <= n_tick + 1)
      `chk("times n", 1'b1, n_sys * 2 >= 3 * n_ext - 4 && n_sys * 2 <= 3 * n_ext + 4)
      @(negedge clock);
      mw = 1'b1;
      mv = 4'h5;
      @(negedge clock);
      mv = 4'h7;
      @(negedge clock);
      mw = 1'b0;
      repeat (3) @(negedge clock);
      `chk("mult b2b", 4'h7, mcr)
      // Loop left running so the converter scenario still sees system edges
   endtask : t_enable
   task automatic t_conv;
      @(negedge clock);
      cw = 1'b1;
      cv = 8'h01;
      @(negedge clock);
      cw = 1'b0;
      count_edges(200);
      // A converter pulse on every rising system edge would give twice the allowed count
      `chk("conv divided", 1'b1, n_cv > 0 && n_cv * 4 <= n_sys + 4)
      tick_run = 1'b0;
   endtask : t_conv
   task automatic t_disabled;
      do_reset(1'b0);
      `chk("mode", clock_select_pkg::mode_disabled, mode)
      count_edges(320);
      `chk("full rate", 1'b1, n_sys >= n_ext - 1 && n_sys <= n_ext + 1)
      strap_level = 1'b1;
      write_mult(4'h3);
      repeat (6) @(negedge clock);
      `chk("mode kept", clock_select_pkg::mode_disabled, mode)
      `chk("mult kept", 4'h0, mcr)
   endtask : t_disabled
   task automatic t_limp;
      do_reset(1'b1);
      run = 1'b0;
      repeat (150) @(negedge clock);
      `chk("mode", clock_select_pkg::mode_limp, mode)
      count_edges(620);
      `chk("fallback rate", 1'b1, n_sys >= 9 && n_sys <= 11)
      run = 1'b1;
   endtask : t_limp
   task automatic tally_and_finish;
      if (error_cnt == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      rst_b = 1'b0;
      run = 1'b1;
      tick_run = 1'b0;
      strap_level = 1'b1;
      mw = 1'b0;
      mv = 4'h0;
      cw = 1'b0;
      cv = 8'h02;
      t_bypass();
      t_enable();
      t_conv();
      t_disabled();
      t_limp();
      tally_and_finish();
   end
   initial begin
      #40000;
      error_cnt++;
      tally_and_finish();
   end
endmodule : tb_top
